// ---- lpmc_core.sv ----
// Low-power mode controller: mode sequencing, wake handling, supply switch and AHB-Lite registers
// Function
// [RULE1] Software drives power-off request low for backup
// [RULE2] Wake event returns power-off request high automatically
// [RULE3] Backup exit by RTC, wake pins, serial, comparator
// [RULE4] Analog rail feeds backup area when both bits set
// [RULE5] Backup area logic stays running always
// [RULE6] Tamper detections recorded with RTC timestamp
// [RULE7] Idle stops processor clock only
// [RULE8] Idle entry and exit fast, full speed
// [RULE9] Slow mode holds processor, peripherals slowly clocked
// [RULE10] Any enabled interrupt exits slow mode, stays slow
// [RULE11] Software moves all clocks to RC first
// [RULE12] Clock-stop entry stops RC oscillator, all clocks
// [RULE13] Wake restarts RC oscillator automatically
// [RULE14] Only wake pins and USB resume wake clock-stop
// [RULE15] External supply keeps backup and memory rails
// [RULE16] Self-refresh config requested via backup pin zero
// [RULE17] External chip applies config on power-off request
// [RULE18] External logic holds memory rail with pin zero
// [RULE19] Record wake source for software after restart
`timescale 1ns/1ps
`include "lpmc_params.svh"
module lpmc_core
	import lpmc_pkg::*;
#(
	parameter int SLOW_DIV_W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rtc_evt,
	input wire logic wake_pin_zero,
	input wire logic [7:0] wake_pin_two_to_nine,
	input wire logic low_power_serial_receiver_evt,
	input wire logic analog_compare_unit_evt,
	input wire logic usb_resume,
	input wire logic tamper_evt,
	input wire logic analog_rail_good,
	input wire logic [31:0] rtc_time,
	input wire logic irq_pending,
	output logic power_off_request_pin_n,
	output logic backup_pin_zero,
	output logic backup_supply_from_analog,
	output logic backup_area_on,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic main_rc_osc_en,
	output logic cpu_wfi_hold,
	output logic irq
);
	lpmc_evt_if #(.W(`LPMC_EV_W)) evt ();

	lpmc_evt_sync #(.W(`LPMC_EV_W)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pins({analog_rail_good, tamper_evt, usb_resume, analog_compare_unit_evt,
			low_power_serial_receiver_evt, wake_pin_two_to_nine, wake_pin_zero, rtc_evt}),
		.evt(evt)
	);

	localparam logic [7:0] RC_START_CYC = 8'(`LPMC_RC_START_CYC);

	function automatic logic [`LPMC_WAKE_W-1:0] pick_wake(input logic [`LPMC_WAKE_W-1:0] rise,
		input logic [`LPMC_WAKE_W-1:0] en, input logic [`LPMC_WAKE_W-1:0] allowed);
		pick_wake = rise & en & allowed;
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// Bus and register state
	logic ph_wr_q, ph_wr_d;
	logic [11:0] ph_addr_q, ph_addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic shutdown_q, shutdown_d;
	logic bkpin0_q, bkpin0_d;
	logic [1:0] mode_req_q, mode_req_d;
	logic mode_go_q, mode_go_d;
	logic [`LPMC_WAKE_W-1:0] wake_en_q, wake_en_d;
	logic [`LPMC_WAKE_W-1:0] wake_src_q, wake_src_d;
	logic switch_control_bit_q, switch_control_bit_d;
	logic switch_software_control_bit_q, switch_software_control_bit_d;
	logic [`LPMC_IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [`LPMC_IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic [31:0] tamper_ts_q, tamper_ts_d;
	logic [SLOW_DIV_W-1:0] slow_div_q, slow_div_d;

	// Sequencer state
	lpmc_state_t state_q, state_d;
	logic [SLOW_DIV_W-1:0] div_cnt_q, div_cnt_d;
	logic slow_tick_q, slow_tick_d;
	logic [7:0] rc_cnt_q, rc_cnt_d;

	logic addr_ph, wr_ph;
	logic [`LPMC_WAKE_W-1:0] wake_rise, backup_hit, stop_hit;
	logic lp_exit;

	always_comb begin
		addr_ph = hsel & htrans[1] & hready;
		wr_ph = ph_wr_q;
		wake_rise = evt.rise[`LPMC_WAKE_W-1:0];
		backup_hit = pick_wake(wake_rise, wake_en_q, `LPMC_BACKUP_WAKE_MASK); // [RULE3]
		stop_hit = pick_wake(wake_rise, wake_en_q, `LPMC_STOP_WAKE_MASK); // [RULE14]
	end

	// Sequencer
	always_comb begin
		state_d = state_q;
		rc_cnt_d = rc_cnt_q;
		lp_exit = 1'b0;
		// Reduced-rate tick; it keeps running in every state so slow entry needs no restart
		if (div_cnt_q >= slow_div_q) begin
			div_cnt_d = '0;
			slow_tick_d = 1'b1;
		end else begin
			div_cnt_d = div_cnt_q + 1'b1;
			slow_tick_d = 1'b0;
		end
		case (state_q)
			LPMC_ST_RUN, LPMC_ST_SLOW_RUN: begin
				if (shutdown_q) begin
					state_d = LPMC_ST_BACKUP; // [RULE1]
				end else if (mode_go_q) begin
					case (mode_req_q)
						`LPMC_MODE_IDLE: state_d = LPMC_ST_IDLE;
						`LPMC_MODE_SLOW: state_d = LPMC_ST_SLOW;
						`LPMC_MODE_STOP: state_d = LPMC_ST_STOP;
						default: state_d = LPMC_ST_RUN;
					endcase
				end
			end
			LPMC_ST_IDLE: begin
				if (irq_pending) begin
					state_d = LPMC_ST_RUN; // [RULE8]
					lp_exit = 1'b1;
				end
			end
			LPMC_ST_SLOW: begin
				if (irq_pending) begin
					state_d = LPMC_ST_SLOW_RUN; // [RULE10]
					lp_exit = 1'b1;
				end
			end
			LPMC_ST_STOP: begin
				if (|stop_hit) begin
					state_d = LPMC_ST_RC_START; // [RULE13]
					rc_cnt_d = RC_START_CYC;
				end
			end
			LPMC_ST_RC_START: begin
				if (rc_cnt_q <= 8'h01) begin
					state_d = LPMC_ST_RUN;
					lp_exit = 1'b1;
				end else begin
					rc_cnt_d = rc_cnt_q - 8'h01;
				end
			end
			LPMC_ST_BACKUP: begin
				if (|backup_hit) begin
					state_d = LPMC_ST_RUN; // [RULE2]
				end
			end
			default: state_d = LPMC_ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= LPMC_ST_RUN;
			div_cnt_q <= '0;
			slow_tick_q <= 1'b0;
			rc_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			div_cnt_q <= div_cnt_d;
			slow_tick_q <= slow_tick_d;
			rc_cnt_q <= rc_cnt_d;
		end
	end

	// Register file
	always_comb begin
		ph_wr_d = addr_ph & hwrite;
		ph_addr_d = addr_ph ? haddr[11:0] : ph_addr_q;
		shutdown_d = shutdown_q;
		bkpin0_d = bkpin0_q;
		mode_req_d = mode_req_q;
		mode_go_d = 1'b0;
		wake_en_d = wake_en_q;
		wake_src_d = wake_src_q;
		switch_control_bit_d = switch_control_bit_q;
		switch_software_control_bit_d = switch_software_control_bit_q;
		irq_stat_d = irq_stat_q;
		irq_mask_d = irq_mask_q;
		tamper_ts_d = tamper_ts_q;
		slow_div_d = slow_div_q;
		if (wr_ph) begin
			if (hit(ph_addr_q, `LPMC_OFS_CTRL)) begin
				shutdown_d = hwdata[`LPMC_CTRL_SHUTDOWN];
				bkpin0_d = hwdata[`LPMC_CTRL_BKPIN0]; // [RULE16]
			end
			if (hit(ph_addr_q, `LPMC_OFS_MODE)) begin
				mode_req_d = hwdata[1:0];
				mode_go_d = 1'b1;
			end
			if (hit(ph_addr_q, `LPMC_OFS_WAKE_EN)) begin
				wake_en_d = hwdata[`LPMC_WAKE_W-1:0];
			end
			if (hit(ph_addr_q, `LPMC_OFS_WAKE_SRC)) begin
				wake_src_d = wake_src_q & ~hwdata[`LPMC_WAKE_W-1:0];
			end
			if (hit(ph_addr_q, `LPMC_OFS_PSW)) begin
				switch_control_bit_d = hwdata[`LPMC_PSW_SWITCH_CONTROL_BIT];
				switch_software_control_bit_d = hwdata[`LPMC_PSW_SWITCH_SOFTWARE_CONTROL_BIT];
			end
			if (hit(ph_addr_q, `LPMC_OFS_IRQ_STAT)) begin
				irq_stat_d = irq_stat_q & ~hwdata[`LPMC_IRQ_W-1:0];
			end
			if (hit(ph_addr_q, `LPMC_OFS_IRQ_MASK)) begin
				irq_mask_d = hwdata[`LPMC_IRQ_W-1:0];
			end
			if (hit(ph_addr_q, `LPMC_OFS_SLOW_DIV)) begin
				slow_div_d = hwdata[SLOW_DIV_W-1:0];
			end
		end
		// Hardware sets after the write so a same-cycle event beats the clear
		if (state_q == LPMC_ST_BACKUP && |backup_hit) begin
			shutdown_d = 1'b0; // [RULE2]
			wake_src_d = backup_hit; // [RULE19]
			irq_stat_d[`LPMC_IRQ_WAKE] = 1'b1;
		end
		if (state_q == LPMC_ST_STOP && |stop_hit) begin
			wake_src_d = stop_hit; // [RULE19]
			irq_stat_d[`LPMC_IRQ_WAKE] = 1'b1;
		end
		if (lp_exit) begin
			irq_stat_d[`LPMC_IRQ_LP_EXIT] = 1'b1;
		end
		if (evt.rise[`LPMC_EV_TAMPER]) begin
			tamper_ts_d = rtc_time; // [RULE6]
			irq_stat_d[`LPMC_IRQ_TAMPER] = 1'b1; // [RULE6]
		end
		rdata_d = 32'h0000_0000;
		if (addr_ph && !hwrite) begin
			case (haddr[11:0])
				`LPMC_OFS_CTRL: rdata_d = {30'h0000_0000, bkpin0_q, shutdown_q};
				`LPMC_OFS_MODE: rdata_d = {30'h0000_0000, mode_req_q};
				`LPMC_OFS_WAKE_EN: rdata_d = {19'h0_0000, wake_en_q};
				`LPMC_OFS_WAKE_SRC: rdata_d = {19'h0_0000, wake_src_q};
				`LPMC_OFS_PSW: rdata_d = {29'h0000_0000, backup_supply_from_analog, switch_software_control_bit_q, switch_control_bit_q};
				`LPMC_OFS_IRQ_STAT: rdata_d = {29'h0000_0000, irq_stat_q};
				`LPMC_OFS_IRQ_MASK: rdata_d = {29'h0000_0000, irq_mask_q};
				`LPMC_OFS_TAMPER_TS: rdata_d = tamper_ts_q;
				`LPMC_OFS_STATE: rdata_d = {29'h0000_0000, state_q};
				`LPMC_OFS_SLOW_DIV: rdata_d = 32'(slow_div_q);
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ph_wr_q <= 1'b0;
			ph_addr_q <= 12'h000;
			rdata_q <= 32'h0000_0000;
			shutdown_q <= 1'b0;
			bkpin0_q <= 1'b0;
			mode_req_q <= `LPMC_MODE_RUN;
			mode_go_q <= 1'b0;
			wake_en_q <= `LPMC_WAKE_EN_RST;
			wake_src_q <= '0;
			switch_control_bit_q <= 1'b0;
			switch_software_control_bit_q <= 1'b0;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			tamper_ts_q <= 32'h0000_0000;
			slow_div_q <= SLOW_DIV_W'(`LPMC_SLOW_DIV_RST);
		end else begin
			ph_wr_q <= ph_wr_d;
			ph_addr_q <= ph_addr_d;
			rdata_q <= rdata_d;
			shutdown_q <= shutdown_d;
			bkpin0_q <= bkpin0_d;
			mode_req_q <= mode_req_d;
			mode_go_q <= mode_go_d;
			wake_en_q <= wake_en_d;
			wake_src_q <= wake_src_d;
			switch_control_bit_q <= switch_control_bit_d;
			switch_software_control_bit_q <= switch_software_control_bit_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			tamper_ts_q <= tamper_ts_d;
			slow_div_q <= slow_div_d;
		end
	end

	// Clock gating follows state; slow tick gates peripherals only in slow mode and both domains in slow run
	always_comb begin
		hrdata = rdata_q;
		hreadyout = 1'b1;
		hresp = 1'b0;
		power_off_request_pin_n = (state_q != LPMC_ST_BACKUP); // [RULE2]
		backup_pin_zero = bkpin0_q; // [RULE16]
		backup_supply_from_analog = switch_control_bit_q & switch_software_control_bit_q & evt.level[`LPMC_EV_ANA_GOOD]; // [RULE4]
		backup_area_on = 1'b1; // [RULE5]
		main_rc_osc_en = (state_q != LPMC_ST_STOP); // [RULE12]
		cpu_wfi_hold = (state_q == LPMC_ST_IDLE) || (state_q == LPMC_ST_SLOW) || (state_q == LPMC_ST_STOP); // [RULE9]
		case (state_q)
			LPMC_ST_RUN: begin
				cpu_clk_en = 1'b1; // [RULE8]
				periph_clk_en = 1'b1;
			end
			LPMC_ST_IDLE: begin
				cpu_clk_en = 1'b0; // [RULE7]
				periph_clk_en = 1'b1; // [RULE7]
			end
			LPMC_ST_SLOW: begin
				cpu_clk_en = 1'b0;
				periph_clk_en = slow_tick_q; // [RULE9]
			end
			LPMC_ST_SLOW_RUN: begin
				cpu_clk_en = slow_tick_q; // [RULE10]
				periph_clk_en = slow_tick_q;
			end
			default: begin
				cpu_clk_en = 1'b0; // [RULE12]
				periph_clk_en = 1'b0;
			end
		endcase
		irq = |(irq_stat_q & irq_mask_q);
	end
endmodule

// ---- lpmc_params.svh ----
// Register offsets, field positions, reset values and timing counts of the low-power mode controller
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH

`define LPMC_OFS_CTRL 12'h000
`define LPMC_OFS_MODE 12'h004
`define LPMC_OFS_WAKE_EN 12'h008
`define LPMC_OFS_WAKE_SRC 12'h00C
`define LPMC_OFS_PSW 12'h010
`define LPMC_OFS_IRQ_STAT 12'h014
`define LPMC_OFS_IRQ_MASK 12'h018
`define LPMC_OFS_TAMPER_TS 12'h01C
`define LPMC_OFS_STATE 12'h020
`define LPMC_OFS_SLOW_DIV 12'h024

`define LPMC_CTRL_SHUTDOWN 0
`define LPMC_CTRL_BKPIN0 1
`define LPMC_PSW_SWITCH_CONTROL_BIT 0
`define LPMC_PSW_SWITCH_SOFTWARE_CONTROL_BIT 1
`define LPMC_PSW_FROM_ANA 2

`define LPMC_MODE_RUN 2'h0
`define LPMC_MODE_IDLE 2'h1
`define LPMC_MODE_SLOW 2'h2
`define LPMC_MODE_STOP 2'h3

`define LPMC_EV_RTC 0
`define LPMC_EV_WK0 1
`define LPMC_EV_WK2 2
`define LPMC_EV_LOW_POWER_SERIAL_RECEIVER 10
`define LPMC_EV_ACC 11
`define LPMC_EV_USB 12
`define LPMC_EV_TAMPER 13
`define LPMC_EV_ANA_GOOD 14
`define LPMC_EV_W 15
`define LPMC_WAKE_W 13

`define LPMC_BACKUP_WAKE_MASK 13'h0_FFF
`define LPMC_STOP_WAKE_MASK 13'h1_3FE

`define LPMC_IRQ_WAKE 0
`define LPMC_IRQ_TAMPER 1
`define LPMC_IRQ_LP_EXIT 2
`define LPMC_IRQ_W 3

`define LPMC_WAKE_EN_RST 13'h0_000
`define LPMC_SLOW_DIV_RST 16'h0010
`define LPMC_CLK_MHZ 20
`define LPMC_RC_START_NS 1000
`define LPMC_RC_START_CYC ((`LPMC_RC_START_NS * `LPMC_CLK_MHZ + 999) / 1000)

`endif

// ---- lpmc_pkg.sv ----
// Types shared by the low-power mode controller modules
package lpmc_pkg;
	typedef enum logic [2:0] {
		LPMC_ST_RUN,
		LPMC_ST_IDLE,
		LPMC_ST_SLOW,
		LPMC_ST_SLOW_RUN,
		LPMC_ST_STOP,
		LPMC_ST_RC_START,
		LPMC_ST_BACKUP
	} lpmc_state_t;
endpackage

// ---- lpmc_evt_if.sv ----
// Synchronised event levels and rising edges passed to the controller core
`timescale 1ns/1ps
interface lpmc_evt_if #(parameter int W = 15);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// ---- lpmc_evt_sync.sv ----
// Two-flop synchronisers and rising-edge detect for asynchronous event pins
`timescale 1ns/1ps
module lpmc_evt_sync #(
	parameter int W = 15
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [W-1:0] pins,
	lpmc_evt_if.src evt
);
	logic [W-1:0] meta_q, meta_d;
	logic [W-1:0] sync_q, sync_d;
	logic [W-1:0] last_q, last_d;
	logic [W-1:0] rise_q, rise_d;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_comb begin
				meta_d[g] = pins[g];
				sync_d[g] = meta_q[g];
				last_d[g] = sync_q[g];
				rise_d[g] = sync_q[g] & ~last_q[g];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
			rise_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
			rise_q <= rise_d;
		end
	end

	assign evt.level = sync_q;
	assign evt.rise = rise_q;
endmodule

// ---- lpmc_core_asserts.sv ----
// Port-level assertions for the low-power mode controller
`timescale 1ns/1ps
module lpmc_core_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic usb_resume,
	input wire logic wake_pin_zero,
	input wire logic [7:0] wake_pin_two_to_nine,
	input wire logic analog_rail_good,
	input wire logic irq_pending,
	input wire logic power_off_request_pin_n,
	input wire logic backup_supply_from_analog,
	input wire logic backup_area_on,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic main_rc_osc_en,
	input wire logic cpu_wfi_hold
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic quiet;
	// Four quiet cycles flush the pin synchronisers
	assign quiet = !usb_resume && !wake_pin_zero && wake_pin_two_to_nine == 8'h00;
	rc_stop_clk_a: assert property (!main_rc_osc_en |-> !cpu_clk_en && !periph_clk_en)
		else $error("clock enable seen with oscillator stopped");
	held_cpu_a: assert property (cpu_wfi_hold |-> !cpu_clk_en)
		else $error("processor clocked while held");
	supply_sel_a: assert property ((!analog_rail_good) [*4] |-> !backup_supply_from_analog)
		else $error("analog supply selected without analog rail");
	backup_on_a: assert property (backup_area_on)
		else $error("backup area switched off");
	stop_no_irq_a: assert property ((!main_rc_osc_en && quiet) [*4] |=> !main_rc_osc_en)
		else $error("clock stop left without a wake pin");
	rc_restart_a: assert property ($rose(main_rc_osc_en) |-> ##[1:40] cpu_clk_en)
		else $error("processor clock not back after oscillator restart");
	lp_exit_a: assert property (cpu_wfi_hold && main_rc_osc_en && irq_pending |-> ##[1:2] !cpu_wfi_hold)
		else $error("interrupt did not release the processor");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	cover property (!main_rc_osc_en);
	cover property ($rose(power_off_request_pin_n));
	cover property (cpu_wfi_hold && irq_pending);
endmodule
bind lpmc_core lpmc_core_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
	.usb_resume(usb_resume), .wake_pin_zero(wake_pin_zero), .wake_pin_two_to_nine(wake_pin_two_to_nine),
	.analog_rail_good(analog_rail_good), .irq_pending(irq_pending), .power_off_request_pin_n(power_off_request_pin_n),
	.backup_supply_from_analog(backup_supply_from_analog), .backup_area_on(backup_area_on), .cpu_clk_en(cpu_clk_en),
	.periph_clk_en(periph_clk_en), .main_rc_osc_en(main_rc_osc_en), .cpu_wfi_hold(cpu_wfi_hold));

// ---- lpmc_psu_model.sv ----
// External supply model: rail enables from power-off request and backup pin zero
`timescale 1ns/1ps
module lpmc_psu_model (
	input wire logic power_off_request_pin_n,
	input wire logic backup_pin_zero,
	output logic main_rails_on,
	output logic memory_rail_enable
);
	// Config applied only once the request pin is low
	assign main_rails_on = power_off_request_pin_n;
	assign memory_rail_enable = power_off_request_pin_n | backup_pin_zero;
endmodule

// ---- low_power_mode_controller_bench.sv ----
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`include "lpmc_params.svh"
module low_power_mode_controller_bench;
	logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, irq_pending = 1'b0, analog_rail_good = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, rtc_time = '0, hrdata, rd;
	logic [31:0] seed = 32'h0001_3582;
	logic [1:0] htrans = 2'h0;
	logic [12:0] ev = '0;
	logic tamper_evt = 1'b0, hready, hreadyout, hresp, pin_n, bpz, from_ana, area_on, cpu_en, per_en, osc_en, hold, irq;
	logic main_on, mem_en;
	int err_total = 0, total_checks = 0, n, b, m_state;
	int exp_q[$];
	always #25 clk_sys = ~clk_sys;
	assign hready = hreadyout;
	lpmc_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rtc_evt(ev[0]), .wake_pin_zero(ev[1]), .wake_pin_two_to_nine(ev[9:2]), .low_power_serial_receiver_evt(ev[10]),
		.analog_compare_unit_evt(ev[11]), .usb_resume(ev[12]), .tamper_evt(tamper_evt),
		.analog_rail_good(analog_rail_good), .rtc_time(rtc_time), .irq_pending(irq_pending),
		.power_off_request_pin_n(pin_n), .backup_pin_zero(bpz), .backup_supply_from_analog(from_ana),
		.backup_area_on(area_on), .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .main_rc_osc_en(osc_en),
		.cpu_wfi_hold(hold), .irq(irq));
	lpmc_psu_model i_psu (.power_off_request_pin_n(pin_n), .backup_pin_zero(bpz), .main_rails_on(main_on),
		.memory_rail_enable(mem_en));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic pulse(input logic [12:0] v);
		ev <= v;
		tick(4);
		ev <= 13'h0_000;
		tick(6);
	endtask
	task automatic st();
		rw(1'b0, `LPMC_OFS_STATE, 32'h0000_0000);
		chk("state", 32'(m_state), rd);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		results();
	end
	initial begin
		tick(4);
		sys_rst <= 1'b0;
		m_state = 0;
		chk("reset pins", 32'h0000_000A, 32'({pin_n, irq, osc_en, hold}));
		chk("area on", 32'h0000_0001, 32'(area_on));
		rw(1'b0, `LPMC_OFS_SLOW_DIV, 32'h0000_0000);
		chk("slow div", 32'h0000_0010, rd);
		rw(1'b0, 12'h0FC, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		for (b = 0; b < 12; b++) begin
			seed = xs(seed);
			rw(1'b1, `LPMC_OFS_IRQ_MASK, 32'(b % 2));
			rw(1'b1, `LPMC_OFS_WAKE_EN, 32'h0000_0001 << b);
			rw(1'b1, `LPMC_OFS_CTRL, {30'h0, seed[0], 1'b1});
			tick(2);
			m_state = 6;
			chk("pin low", 32'h0000_0000, 32'(pin_n));
			chk("mem rail", 32'(seed[0]), 32'({main_on, mem_en}));
			pulse(13'h0_001 << ((b + 1) % 13));
			st();
			exp_q.push_back(1 << b);
			pulse(13'h0_001 << b);
			m_state = 0;
			chk("pin high", 32'h0000_0001, 32'(pin_n));
			st();
			rw(1'b0, `LPMC_OFS_WAKE_SRC, 32'h0000_0000);
			chk("wake src", 32'(exp_q.pop_front()), rd);
			rw(1'b1, `LPMC_OFS_WAKE_SRC, rd);
			chk("irq", 32'(b % 2), 32'(irq));
			rw(1'b1, `LPMC_OFS_IRQ_STAT, 32'h0000_0001);
			// Clear lands at the edge that ends the data phase
			tick(1);
			chk("irq clear", 32'h0000_0000, 32'(irq));
		end
		for (b = 0; b < 8; b++) begin
			analog_rail_good <= b[2];
			rw(1'b1, `LPMC_OFS_PSW, 32'(b[1:0]));
			tick(4);
			chk("supply sel", 32'(b == 7), 32'(from_ana));
			rw(1'b0, `LPMC_OFS_PSW, 32'h0000_0000);
			chk("psw", 32'(b[1:0]) | 32'(b == 7) << 2, rd);
		end
		seed = xs(seed);
		rtc_time <= seed;
		tamper_evt <= 1'b1;
		tick(4);
		tamper_evt <= 1'b0;
		tick(6);
		rw(1'b0, `LPMC_OFS_TAMPER_TS, 32'h0000_0000);
		chk("tamper ts", seed, rd);
		rw(1'b0, `LPMC_OFS_IRQ_STAT, 32'h0000_0000);
		chk("tamper stat", 32'h0000_0002, rd & 32'h0000_0002);
		rw(1'b1, `LPMC_OFS_MODE, 32'h0000_0001);
		tick(2);
		chk("idle clocks", 32'h0000_0005, 32'({hold, cpu_en, per_en}));
		irq_pending <= 1'b1;
		tick(2);
		irq_pending <= 1'b0;
		chk("idle exit", 32'h0000_0003, 32'({hold, cpu_en, per_en}));
		rw(1'b1, `LPMC_OFS_SLOW_DIV, 32'h0000_0003);
		rw(1'b1, `LPMC_OFS_MODE, 32'h0000_0002);
		tick(2);
		m_state = 2;
		st();
		// Period of four cycles gives ten pulses in any forty
		n = 0;
		repeat (40) begin
			tick(1);
			n += per_en + 100 * cpu_en;
		end
		chk("slow pulses", 32'd10, 32'(n));
		irq_pending <= 1'b1;
		tick(2);
		irq_pending <= 1'b0;
		m_state = 3;
		st();
		n = 0;
		repeat (40) begin
			tick(1);
			n += cpu_en;
		end
		chk("slow run", 32'd10, 32'(n));
		rw(1'b1, `LPMC_OFS_MODE, 32'h0000_0000);
		rw(1'b1, `LPMC_OFS_WAKE_EN, 32'h0000_1FFF);
		for (b = 1; b < 13; b++) begin
			if (b < 10 || b == 12) begin
				// Clock sources are taken as already moved to the RC oscillator
				rw(1'b1, `LPMC_OFS_MODE, 32'h0000_0003);
				irq_pending <= 1'b1;
				pulse(13'h0_C01);
				irq_pending <= 1'b0;
				chk("stop clocks", 32'h0000_0000, 32'({osc_en, cpu_en, per_en}));
				exp_q.push_back(1 << b);
				pulse(13'h0_001 << b);
				chk("rc on", 32'h0000_0001, 32'(osc_en));
				n = 0;
				while (cpu_en !== 1'b1 && n < 60) begin
					tick(1);
					n++;
				end
				chk("rc wait", 32'h0000_0001, 32'(n < 60));
				m_state = 0;
				st();
				rw(1'b0, `LPMC_OFS_WAKE_SRC, 32'h0000_0000);
				chk("stop src", 32'(exp_q.pop_front()), rd);
			end
		end
		results();
	end
endmodule
